/* File: src/smsp_pkg.sv */
// Constants and carrier types for the master/slave serial port.
// Assumes a single 100 MHz system clock shared by all users of the package.
package smsp_pkg;

	// Register offsets on the CPU data space
	localparam logic [7:0] SMSP_CTRL_OFS = 8'h4c;
	localparam logic [7:0] SMSP_STAT_OFS = 8'h4d;
	localparam logic [7:0] SMSP_DATA_OFS = 8'h4e;

	// Control register fields
	localparam int CTRL_IRQ_EN   = 7;
	localparam int CTRL_ENABLE   = 6;
	localparam int CTRL_LSB      = 5;
	localparam int CTRL_MASTER   = 4;
	localparam int CTRL_CPOL     = 3;
	localparam int CTRL_CPHA     = 2;
	localparam int CTRL_RATE_HI  = 1;
	localparam int CTRL_RATE_LO  = 0;

	// Status register fields
	localparam int STAT_DONE     = 7;
	localparam int STAT_WCOL     = 6;
	localparam int STAT_DBL      = 0;

	localparam logic [7:0] SMSP_CTRL_RST = 8'h00;
	localparam logic [7:0] SMSP_STAT_RST = 8'h00;
	localparam logic [7:0] SMSP_DATA_RST = 8'h00;

	// SCK half periods in system clocks, indexed by {double, rate}
	localparam logic [6:0] HALF_DIV4   = 7'h02;
	localparam logic [6:0] HALF_DIV16  = 7'h08;
	localparam logic [6:0] HALF_DIV64  = 7'h20;
	localparam logic [6:0] HALF_DIV128 = 7'h40;
	localparam logic [6:0] HALF_DIV2   = 7'h01;
	localparam logic [6:0] HALF_DIV8   = 7'h04;
	localparam logic [6:0] HALF_DIV32  = 7'h10;

	// Last SCK edge index of a master byte, and bits per byte
	localparam logic [3:0] LAST_EDGE   = 4'hf;
	localparam logic [3:0] BITS_BYTE   = 4'h8;

	localparam int FIFO_DEPTH_DEF = 16;

	typedef struct packed {
		logic [7:0] addr;
		logic       wr;
		logic       rd;
		logic [7:0] wdata;
	} smsp_cpu_req_t;

	typedef struct packed {
		logic i;
		logic o;
		logic oe;
	} smsp_pin_t;

endpackage : smsp_pkg

/* File: src/smsp_fifo.sv */
// Synchronous FIFO with valid/ready on both sides.
// Assumes both sides run on the same clock and reset.
`timescale 1ns/10ps
module smsp_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input  wire logic             clk,
	input  wire logic             nrst,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic [WIDTH-1:0]      out_data
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	initial begin
		if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
			$error("smsp_fifo: DEPTH must be a power of two >= 2");
	end

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr_q;
	logic [AW-1:0]    rd_ptr_q;
	logic [AW:0]      count_q;
	logic             push;
	logic             pop;

	assign in_ready  = (count_q < (AW+1)'(DEPTH));
	assign out_valid = (count_q != '0);
	assign out_data  = mem[rd_ptr_q];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	always_ff @(posedge clk) begin
		if (push)
			mem[wr_ptr_q] <= in_data;
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
			count_q  <= '0;
		end else begin
			if (push)
				wr_ptr_q <= wr_ptr_q + 1'b1;
			if (pop)
				rd_ptr_q <= rd_ptr_q + 1'b1;
			if (push && !pop)
				count_q <= count_q + 1'b1;
			else if (pop && !push)
				count_q <= count_q - 1'b1;
		end
	end

endmodule : smsp_fifo

/* File: src/smsp_port.sv */
// Byte-oriented serial port, master or slave, with three CPU registers.
// Assumes pin inputs synchronous to clk and a simple CPU strobe bus.
//
// Summary of operation
// - Slave active only while select low
// - Select high resets slave shift logic
// - Select output in master is plain GPIO
// - Select low in master forces slave role when select is an input
// - Forced slave switch sets transfer-complete flag
// - Mode number maps to polarity and phase
// - Polarity bit sets SCK idle level
// - Phase bit picks sample or setup edge
// - Port idle unless enable bit set
// - Bit-order bit selects LSB or MSB first
// - Master SCK divider from three rate bits
// - Rate bits ignored in slave role
// - Byte done sets flag, may raise interrupt
// - Flag cleared by vector or status-data sequence
// - Data write while busy sets collision
// - Status-data sequence clears collision and done
// - Data write starts; read gives receive buffer
// - Master shifts eight bits then stops
// - Single transmit buffer; receive via shift register, FIFO_DEPTH-entry FIFO and buffer
`timescale 1ns/10ps
module smsp_port
	import smsp_pkg::*;
#(
	parameter int FIFO_DEPTH = smsp_pkg::FIFO_DEPTH_DEF
) (
	input  wire logic                   clk,
	input  wire logic                   nrst,
	input  wire smsp_pkg::smsp_cpu_req_t cpu_req,
	output logic [7:0]                  rdata_q,
	input  wire logic                   global_irq_en,
	input  wire logic                   irq_vector_ack,
	output logic                        irq_q,
	input  wire logic                   ss_dir_out,
	input  wire logic                   ss_gpo_level,
	input  wire logic                   sck_i,
	output logic                        sck_o_q,
	output logic                        sck_oe_q,
	input  wire logic                   mosi_i,
	output logic                        mosi_o_q,
	output logic                        mosi_oe_q,
	input  wire logic                   miso_i,
	output logic                        miso_o_q,
	output logic                        miso_oe_q,
	input  wire logic                   ss_i,
	output logic                        ss_o_q,
	output logic                        ss_oe_q
);
	import smsp_pkg::*;

	initial begin
		if (FIFO_DEPTH < 2)
			$error("smsp_port: FIFO_DEPTH must be at least 2");
	end

	typedef enum logic [1:0] {
		SMSP_M_IDLE = 2'b01,
		SMSP_M_RUN  = 2'b10
	} smsp_mstate_t;

	smsp_mstate_t mstate_q;
	logic [7:0]   ctrl_q;
	logic         done_q;
	logic         wcol_q;
	logic         dbl_q;
	logic [7:0]   tx_q;
	logic [7:0]   rx_sh_q;
	logic [7:0]   rx_buf_q;
	logic [3:0]   bitcnt_q;
	logic [3:0]   edge_q;
	logic [6:0]   div_q;
	logic         out_q;
	logic         sck_prev_q;
	logic         arm_q;
	logic         start_pend_q;

	logic en, master, cpol, cpha, lsb;
	logic wr_ctrl, wr_stat, wr_data, rd_stat, rd_data, acc_data;
	logic slave_act, forced_slave, busy;
	logic tick, sck_edge, lead, sample, setup;
	logic byte_done, clr_flags;
	logic [6:0] half;
	logic [7:0] rx_next;
	logic fifo_in_ready, fifo_out_valid, fifo_out_ready;
	logic [7:0] fifo_out_data;

	assign en     = ctrl_q[CTRL_ENABLE];
	assign master = ctrl_q[CTRL_MASTER];
	assign cpol   = ctrl_q[CTRL_CPOL];
	assign cpha   = ctrl_q[CTRL_CPHA];
	assign lsb    = ctrl_q[CTRL_LSB];

	assign wr_ctrl  = cpu_req.wr && cpu_req.addr == SMSP_CTRL_OFS;
	assign wr_stat  = cpu_req.wr && cpu_req.addr == SMSP_STAT_OFS;
	assign wr_data  = cpu_req.wr && cpu_req.addr == SMSP_DATA_OFS;
	assign rd_stat  = cpu_req.rd && cpu_req.addr == SMSP_STAT_OFS;
	assign rd_data  = cpu_req.rd && cpu_req.addr == SMSP_DATA_OFS;
	assign acc_data = wr_data || rd_data;

	// Bit selected for transmission at a given count
	function automatic logic tx_bit(input logic [7:0] d, input logic [3:0] i,
		input logic lsb_first);
		logic [2:0] k;
		k = i[2:0];
		tx_bit = lsb_first ? d[k] : d[3'd7 - k];
	endfunction : tx_bit

	// Master rate select, ignored in slave role
	always_comb begin
		case ({dbl_q, ctrl_q[CTRL_RATE_HI], ctrl_q[CTRL_RATE_LO]})
			3'b000:  half = HALF_DIV4;
			3'b001:  half = HALF_DIV16;
			3'b010:  half = HALF_DIV64;
			3'b011:  half = HALF_DIV128;
			3'b100:  half = HALF_DIV2;
			3'b101:  half = HALF_DIV8;
			3'b110:  half = HALF_DIV32;
			default: half = HALF_DIV64;
		endcase
	end

	assign forced_slave = en && master && !ss_dir_out && !ss_i;
	assign slave_act    = en && !master && !ss_i;
	assign busy = (mstate_q == SMSP_M_RUN) || start_pend_q ||
		(slave_act && bitcnt_q != 4'h0);

	// Edge sources: divider in master, sampled pin in slave
	assign tick     = (mstate_q == SMSP_M_RUN) && div_q == 7'h01;
	assign sck_edge = master ? tick : (slave_act && sck_i != sck_prev_q);
	// Leading edge leaves the idle level
	assign lead   = master ? !edge_q[0] : (sck_i != cpol);
	assign sample = sck_edge && (lead ^ cpha);
	assign setup  = sck_edge && !(lead ^ cpha);

	assign rx_next = lsb ? {(master ? miso_i : mosi_i), rx_sh_q[7:1]}
		: {rx_sh_q[6:0], (master ? miso_i : mosi_i)};

	assign byte_done = master ? (tick && edge_q == LAST_EDGE)
		: (sample && bitcnt_q == BITS_BYTE - 4'h1);

	assign clr_flags = arm_q && acc_data;

	// Buffer is held between a status read with a flag set and the data access
	assign fifo_out_ready = !arm_q;

	smsp_fifo #(
		.WIDTH (8),
		.DEPTH (FIFO_DEPTH)
	) u_rx_fifo (
		.clk       (clk),
		.nrst      (nrst),
		.in_valid  (byte_done),
		.in_ready  (fifo_in_ready),
		.in_data   ((master && !cpha) ? rx_sh_q : rx_next),
		.out_valid (fifo_out_valid),
		.out_ready (fifo_out_ready),
		.out_data  (fifo_out_data)
	);

	// Control register; hardware drops master on external select
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			ctrl_q <= SMSP_CTRL_RST;
		else if (wr_ctrl)
			ctrl_q <= cpu_req.wdata;
		else if (forced_slave)
			ctrl_q[CTRL_MASTER] <= 1'b0;
	end

	// Only the double-rate bit is writable in status
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			dbl_q <= SMSP_STAT_RST[STAT_DBL];
		else if (wr_stat)
			dbl_q <= cpu_req.wdata[STAT_DBL];
	end

	// Done flag: hardware set wins over any clear
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			done_q <= 1'b0;
		else if (byte_done || forced_slave)
			done_q <= 1'b1;
		else if (irq_vector_ack || clr_flags)
			done_q <= 1'b0;
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			wcol_q <= 1'b0;
		else if (wr_data && busy)
			wcol_q <= 1'b1;
		else if (clr_flags)
			wcol_q <= 1'b0;
	end

	// Status read with a flag set arms the clear
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			arm_q <= 1'b0;
		else if (rd_stat)
			arm_q <= done_q || wcol_q;
		else if (acc_data)
			arm_q <= 1'b0;
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			tx_q <= SMSP_DATA_RST;
		else if (wr_data && !busy)
			tx_q <= cpu_req.wdata;
	end

	// Master waits for room in the receive path before starting
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			start_pend_q <= 1'b0;
		else if (!en || !master || forced_slave)
			start_pend_q <= 1'b0;
		else if (wr_data && !busy)
			start_pend_q <= 1'b1;
		else if (mstate_q == SMSP_M_IDLE && fifo_in_ready)
			start_pend_q <= 1'b0;
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			mstate_q <= SMSP_M_IDLE;
		else begin
			case (mstate_q)
				SMSP_M_IDLE:
					if (start_pend_q && fifo_in_ready && en && master &&
						!forced_slave)
						mstate_q <= SMSP_M_RUN;
				SMSP_M_RUN:
					if (forced_slave || !en || !master || byte_done)
						mstate_q <= SMSP_M_IDLE;
				default:
					mstate_q <= SMSP_M_IDLE;
			endcase
		end
	end

	// Half-period divider and SCK edge index
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			div_q  <= 7'h01;
			edge_q <= 4'h0;
		end else if (mstate_q != SMSP_M_RUN) begin
			div_q  <= half;
			edge_q <= 4'h0;
		end else if (tick) begin
			div_q  <= half;
			edge_q <= edge_q + 4'h1;
		end else
			div_q <= div_q - 7'h01;
	end

	// Shift logic; disable, select high in slave role or forced slave clears it
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			bitcnt_q <= 4'h0;
			rx_sh_q  <= 8'h00;
			out_q    <= 1'b0;
		end else if (!en || (!master && ss_i) || forced_slave) begin
			bitcnt_q <= 4'h0;
			rx_sh_q  <= 8'h00;
			out_q    <= tx_bit(tx_q, 4'h0, lsb);
		end else if (mstate_q == SMSP_M_IDLE && master) begin
			bitcnt_q <= 4'h0;
			out_q    <= tx_bit(tx_q, 4'h0, lsb);
		end else if (byte_done) begin
			bitcnt_q <= 4'h0;
			rx_sh_q  <= rx_next;
			out_q    <= tx_bit(tx_q, 4'h0, lsb);
		end else begin
			if (sample) begin
				rx_sh_q  <= rx_next;
				bitcnt_q <= bitcnt_q + 4'h1;
			end
			if (setup)
				out_q <= tx_bit(tx_q, bitcnt_q, lsb);
		end
	end

	// Receive buffer keeps the last byte popped from the receive FIFO
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			rx_buf_q <= SMSP_DATA_RST;
		else if (fifo_out_valid && fifo_out_ready)
			rx_buf_q <= fifo_out_data;
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			sck_prev_q <= 1'b0;
		else
			sck_prev_q <= sck_i;
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			rdata_q <= 8'h00;
		else if (cpu_req.rd) begin
			case (cpu_req.addr)
				SMSP_CTRL_OFS: rdata_q <= ctrl_q;
				SMSP_STAT_OFS: rdata_q <= {done_q, wcol_q, 5'h00, dbl_q};
				SMSP_DATA_OFS: rdata_q <= rx_buf_q;
				default:       rdata_q <= 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			irq_q <= 1'b0;
		else
			irq_q <= done_q && ctrl_q[CTRL_IRQ_EN] && global_irq_en;
	end

	// Pin drivers; slave never drives SCK, MOSI or select
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			sck_o_q   <= 1'b0;
			sck_oe_q  <= 1'b0;
			mosi_o_q  <= 1'b0;
			mosi_oe_q <= 1'b0;
			miso_o_q  <= 1'b0;
			miso_oe_q <= 1'b0;
			ss_o_q    <= 1'b0;
			ss_oe_q   <= 1'b0;
		end else begin
			sck_o_q   <= (mstate_q == SMSP_M_RUN) ?
				(cpol ^ edge_q[0] ^ tick) : cpol;
			sck_oe_q  <= en && master && !forced_slave;
			// Setup bit leaves with its own SCK edge, not a cycle late
			mosi_o_q  <= setup ? tx_bit(tx_q, bitcnt_q, lsb) : out_q;
			mosi_oe_q <= en && master && !forced_slave;
			miso_o_q  <= out_q;
			miso_oe_q <= slave_act;
			ss_o_q    <= ss_gpo_level;
			ss_oe_q   <= en && master && ss_dir_out;
		end
	end

endmodule : smsp_port

/* File: bench/smsp_port_assertions.sv */
// Port-level checker for the serial port.
// Bound into every smsp_port; sees only its ports.
`timescale 1ns/10ps
module smsp_port_assertions
	import smsp_pkg::*;
#(
	parameter int FIFO_DEPTH = 16
) (
	input wire logic                    clk,
	input wire logic                    nrst,
	input wire smsp_pkg::smsp_cpu_req_t cpu_req,
	input wire logic [7:0]              rdata_q,
	input wire logic                    global_irq_en,
	input wire logic                    irq_q,
	input wire logic                    ss_dir_out,
	input wire logic                    ss_gpo_level,
	input wire logic                    ss_i,
	input wire logic                    sck_oe_q,
	input wire logic                    mosi_oe_q,
	input wire logic                    miso_oe_q,
	input wire logic                    ss_o_q,
	input wire logic                    ss_oe_q
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);
	logic unmapped;
	assign unmapped = cpu_req.rd && !(cpu_req.addr inside
		{SMSP_CTRL_OFS, SMSP_STAT_OFS, SMSP_DATA_OFS});
	chk_irq_gated:
	assert property (irq_q |-> $past(global_irq_en))
		else $error("irq without global enable");
	chk_unmapped_zero:
	assert property (unmapped |=> rdata_q == 8'h00)
		else $error("unmapped read not zero");
	chk_stat_unused:
	assert property (cpu_req.rd && cpu_req.addr == SMSP_STAT_OFS
		|=> rdata_q[5:1] == 5'h00)
		else $error("unused status bits set");
	chk_ss_plain_out:
	assert property (ss_oe_q && $past(ss_oe_q)
		|-> ss_o_q == $past(ss_gpo_level))
		else $error("select output not plain level");
	chk_ss_drop_role:
	assert property (sck_oe_q && !ss_dir_out && !ss_i
		|-> ##[1:2] !sck_oe_q)
		else $error("master kept clock after select low");
	chk_oe_pair:
	assert property (sck_oe_q == mosi_oe_q)
		else $error("clock and data enables differ");
	chk_miso_quiet:
	assert property (ss_i [*4] |-> !miso_oe_q)
		else $error("miso driven while deselected");
	chk_miso_role:
	assert property (miso_oe_q |-> !sck_oe_q)
		else $error("miso driven in master role");
	cover property (sck_oe_q && !ss_dir_out && !ss_i);
	cover property ($rose(irq_q));
	cover property ($rose(miso_oe_q));
endmodule : smsp_port_assertions

bind smsp_port smsp_port_assertions #(.FIFO_DEPTH(FIFO_DEPTH))
	smsp_port_assertions_inst (.clk, .nrst, .cpu_req, .rdata_q,
	.global_irq_en, .irq_q, .ss_dir_out, .ss_gpo_level, .ss_i,
	.sck_oe_q, .mosi_oe_q, .miso_oe_q, .ss_o_q, .ss_oe_q);

/* File: bench/smsp_peer.sv */
// Behavioural far-side slave for master-role transfers.
// Assumes sck/mosi from the port and ss_n from its select output.
`timescale 1ns/10ps
module smsp_peer (
	input  wire logic       sck,
	input  wire logic       mosi,
	input  wire logic       ss_n,
	input  wire logic       cpol,
	input  wire logic       cpha,
	input  wire logic       lsb,
	input  wire logic [7:0] tx,
	output logic            miso,
	output logic [7:0]      rx
);
	logic [7:0] sh;
	initial begin
		miso = 1'b0;
		rx = 8'h00;
		sh = 8'h00;
	end
	task automatic put();
		miso = lsb ? sh[0] : sh[7];
		sh = lsb ? sh >> 1 : sh << 1;
	endtask : put
	always @(negedge ss_n) begin
		sh = tx;
		if (!cpha) put();
	end
	// Released line flips so a stale bit cannot pass
	always @(posedge ss_n) miso = ~miso;
	always @(sck) begin
		if (!ss_n && ((sck != cpol) ^ cpha))
			rx = lsb ? {mosi, rx[7:1]} : {rx[6:0], mosi};
		else if (!ss_n)
			put();
	end
endmodule : smsp_peer

/* File: bench/smsp_port_tb.sv */
// Self-checking bench for smsp_port with a slave peer.
// Bench plays external master itself for slave-role traffic.
`timescale 1ns/10ps
module smsp_port_tb;
	import smsp_pkg::*;
	localparam int DIV [8] = '{4, 16, 64, 128, 2, 8, 32, 64};
	logic          clk, nrst, g_ie, ack, ss_dir, ss_gpo;
	logic          tb_sck, tb_mosi, ss_drv, p_cpol, p_cpha, p_lsb;
	logic [7:0]    rdata_q, p_tx, p_rx;
	logic          irq_q, sck_o_q, sck_oe_q, mosi_o_q, mosi_oe_q;
	logic          miso_o_q, miso_oe_q, ss_o_q, ss_oe_q, p_miso, sk_p;
	smsp_cpu_req_t req;
	int            n_errors, total_checks, ne, t0, t1, cnt;
	wire sck_w  = sck_oe_q ? sck_o_q : tb_sck;
	wire mosi_w = mosi_oe_q ? mosi_o_q : tb_mosi;
	wire miso_w = miso_oe_q ? miso_o_q : p_miso;
	wire ss_w   = ss_oe_q ? ss_o_q : ss_drv;
	smsp_port smsp_port_inst (.clk, .nrst, .cpu_req(req), .rdata_q,
		.global_irq_en(g_ie), .irq_vector_ack(ack), .irq_q,
		.ss_dir_out(ss_dir), .ss_gpo_level(ss_gpo), .sck_i(sck_w),
		.sck_o_q, .sck_oe_q, .mosi_i(mosi_w), .mosi_o_q, .mosi_oe_q,
		.miso_i(miso_w), .miso_o_q, .miso_oe_q, .ss_i(ss_w),
		.ss_o_q, .ss_oe_q);
	smsp_peer smsp_peer_inst (.sck(sck_w), .mosi(mosi_w), .ss_n(ss_w),
		.cpol(p_cpol), .cpha(p_cpha), .lsb(p_lsb), .tx(p_tx),
		.miso(p_miso), .rx(p_rx));
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : end_of_test
	always @(posedge clk) begin
		cnt++;
		if (sck_o_q !== sk_p) begin
			if (ne == 0) t0 = cnt;
			t1 = cnt;
			ne++;
		end
		sk_p = sck_o_q;
		if (cnt > 40000) begin
			n_errors++;
			end_of_test();
		end
	end
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : cyc
	task automatic chk(input string s, input logic [15:0] e,
		input logic [15:0] g);
		total_checks++;
		if (g !== e) begin
			$display("Error %s expected %h seen %h", s, e, g);
			n_errors++;
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		req = '{a, 1'b1, 1'b0, d};
		cyc(1);
		req.wr = 1'b0;
		cyc(1);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		req = '{a, 1'b0, 1'b1, 8'h00};
		cyc(1);
		req.rd = 1'b0;
		cyc(1);
		chk($sformatf("read %h", a), e, rdata_q);
	endtask : rd
	task automatic wait_edges();
		for (int k = 0; k < 3000 && ne < 16; k++) cyc(1);
		cyc(4);
	endtask : wait_edges
	task automatic wait_irq();
		for (int k = 0; k < 200 && irq_q !== 1'b1; k++) cyc(1);
	endtask : wait_irq
	// Half periods of four clocks stay inside the slave's limits
	task automatic sbits(input logic [7:0] d, input int n,
		output logic [7:0] g);
		for (int b = 7; b > 7 - n; b--) begin
			tb_mosi = d[b];
			cyc(4);
			g[b] = miso_w;
			tb_sck = 1'b1;
			cyc(4);
			tb_sck = 1'b0;
		end
	endtask : sbits
	task automatic t_regs();
		rd(SMSP_CTRL_OFS, SMSP_CTRL_RST);
		rd(SMSP_STAT_OFS, SMSP_STAT_RST);
		rd(8'h4f, 8'h00);
		wr(SMSP_STAT_OFS, 8'hff);
		rd(SMSP_STAT_OFS, 8'h01);
		wr(SMSP_STAT_OFS, 8'h00);
		wr(SMSP_CTRL_OFS, 8'h10);
		ne = 0;
		wr(SMSP_DATA_OFS, 8'h77);
		cyc(40);
		chk("edges off", 0, ne);
		rd(SMSP_STAT_OFS, 8'h00);
		$display("t_regs done");
	endtask : t_regs
	task automatic t_master();
		logic [7:0] b;
		for (int i = 0; i < 8; i++) begin
			b = 8'hb4 ^ 8'(i);
			{p_lsb, p_cpol, p_cpha} = 3'(i);
			p_tx = 8'h1d + 8'(i * 37);
			wr(SMSP_STAT_OFS, {7'h00, p_lsb});
			wr(SMSP_CTRL_OFS, {2'b01, p_lsb, 1'b1, p_cpol, p_cpha,
				p_cpol, p_cpha});
			ss_gpo = 1'b0;
			cyc(2);
			ne = 0;
			wr(SMSP_DATA_OFS, b);
			wait_edges();
			chk("edges", 16, ne);
			chk("span", 15 * DIV[i] / 2, 16'(t1 - t0));
			chk("idle", p_cpol, sck_o_q);
			chk("peer", b, p_rx);
			ss_gpo = 1'b1;
			rd(SMSP_STAT_OFS, {7'h00, p_lsb} | 8'h80);
			rd(SMSP_DATA_OFS, p_tx);
			rd(SMSP_STAT_OFS, {7'h00, p_lsb});
		end
		wr(SMSP_STAT_OFS, 8'h00);
		$display("t_master done");
	endtask : t_master
	task automatic t_collide();
		{p_lsb, p_cpol, p_cpha} = 3'b000;
		p_tx = 8'h5a;
		wr(SMSP_CTRL_OFS, 8'hd0);
		ss_gpo = 1'b0;
		cyc(2);
		wr(SMSP_DATA_OFS, 8'h11);
		wr(SMSP_DATA_OFS, 8'h22);
		wait_irq();
		chk("irq", 1, irq_q);
		rd(SMSP_STAT_OFS, 8'hc0);
		chk("peer", 8'h11, p_rx);
		rd(SMSP_DATA_OFS, 8'h5a);
		rd(SMSP_STAT_OFS, 8'h00);
		chk("irq", 0, irq_q);
		wr(SMSP_DATA_OFS, 8'h33);
		wait_irq();
		ack = 1'b1;
		cyc(1);
		ack = 1'b0;
		cyc(2);
		chk("irq", 0, irq_q);
		rd(SMSP_STAT_OFS, 8'h00);
		ss_gpo = 1'b1;
		$display("t_collide done");
	endtask : t_collide
	task automatic t_drop();
		wr(SMSP_CTRL_OFS, 8'h50);
		ss_dir = 1'b0;
		cyc(2);
		ss_drv = 1'b0;
		cyc(3);
		chk("sck oe", 0, sck_oe_q);
		rd(SMSP_CTRL_OFS, 8'h40);
		rd(SMSP_STAT_OFS, 8'h80);
		wr(SMSP_DATA_OFS, 8'h00);
		rd(SMSP_STAT_OFS, 8'h00);
		ss_drv = 1'b1;
		ss_dir = 1'b1;
		wr(SMSP_CTRL_OFS, 8'h50);
		rd(SMSP_CTRL_OFS, 8'h50);
		$display("t_drop done");
	endtask : t_drop
	task automatic t_slave();
		logic [7:0] g;
		wr(SMSP_CTRL_OFS, 8'h43);
		ss_drv = 1'b0;
		cyc(4);
		sbits(8'hff, 3, g);
		ss_drv = 1'b1;
		cyc(4);
		wr(SMSP_DATA_OFS, 8'ha5);
		ss_drv = 1'b0;
		cyc(4);
		sbits(8'h96, 8, g);
		cyc(8);
		chk("miso oe", 1, miso_oe_q);
		ss_drv = 1'b1;
		chk("miso", 8'ha5, g);
		rd(SMSP_STAT_OFS, 8'h80);
		rd(SMSP_DATA_OFS, 8'h96);
		$display("t_slave done");
	endtask : t_slave
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		nrst = 1'b0;
		req = '0;
		{g_ie, ack, ss_dir, ss_gpo, tb_sck, tb_mosi} = 6'b101100;
		ss_drv = 1'b1;
		{p_cpol, p_cpha, p_lsb, p_tx} = 11'h000;
		cyc(3);
		nrst = 1'b1;
		t_regs();
		t_master();
		t_collide();
		t_drop();
		t_slave();
		end_of_test();
	end
endmodule : smsp_port_tb
